// ===== src/uxs_defines.vh
`ifndef UXS_DEFINES_VH
`define UXS_DEFINES_VH
// ****************************************
// Register byte addresses
// ****************************************
`define UXS_A_DATA 8'h00
`define UXS_A_IER 8'h04
`define UXS_A_ISR 8'h08
`define UXS_A_EFR 8'h0C
`define UXS_A_LCR 8'h10
`define UXS_A_MCR 8'h14
`define UXS_A_MSR 8'h18
`define UXS_A_XON1 8'h1C
`define UXS_A_XON2 8'h20
`define UXS_A_XOFF1 8'h24
`define UXS_A_SPECIAL_MATCH_CHAR 8'h28
`define UXS_A_DIV 8'h2C
`define UXS_A_TRIG 8'h30
// ****************************************
// Field positions
// ****************************************
`define UXS_IER_XOFF 5
`define UXS_IER_SLEEP 4
`define UXS_ISR_NOINT 0
`define UXS_ISR_FLOW 4
`define UXS_EFR_ENH 4
`define UXS_EFR_SPEC 5
`define UXS_MCR_INV 2
`define UXS_MCR_IR 6
`define UXS_LCR_STOP 2
`define UXS_LCR_PAR 3
// ****************************************
// Reset values and keys
// ****************************************
`define UXS_XCHAR_RST 8'h00
`define UXS_DIV_RST 16'h0001
`define UXS_LCR_RST 8'h03
`define UXS_LCR_KEY 8'hBF
// ****************************************
// Timing counts
// ****************************************
`define UXS_TICKS_PER_BIT 9'd16
`define UXS_IR_PULSE_TICKS 4'd3
`define UXS_IR_CNT_MAX 4'hF
`endif

// ===== src/uxs_top.v
// Overview of operation
// (RQ1) Compare received chars with flow characters
// (RQ2) Xoff match pauses transmitter after current char
// (RQ3) Enabled Xoff match sets flag and interrupt
// (RQ4) Xon match resumes transmit, clears flag
// (RQ5) Reset clears all flow character registers
// (RQ6) Double mode matches two consecutive chars
// (RQ7) Consumed flow characters never reach receive store
// (RQ8) Trigger crossing sends Xoff after two chars
// (RQ9) Xon sent one trigger step below
// (RQ10) Special char stored and flags status bit
// (RQ11) Compare only selected word length bits
// (RQ12) Infrared zero bit gives 3/16 pulse
// (RQ13) Infrared mode enables encoder, decoder, idle zero
// (RQ14) Decoder pulse gives high bit, optional invert
// (RQ15) Sleep only when all idle conditions hold
// (RQ16) Sleep stops the oscillator output
// (RQ17) Start edge, data write, modem change wake
// (RQ18) Resleep after service, never with pending interrupt
// (RQ19) Modem status read clears change indications
// (RQ20) Sleep stays armed until enable cleared
// (RQ21) Xoff and sleep enables need enhanced bit
// (RQ22) Flow characters reachable only under key value
// (RQ23) Flow chars inserted only between characters
// (RQ24) Xoff delay counted from divisor and frame
`timescale 1ns/100ps
`include "uxs_defines.vh"
module uxs_top (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata_ff,
  output reg pready_ff,
  output reg pslverr_ff,
  input wire rx_char_valid,
  input wire [7:0] rx_char,
  input wire [5:0] rx_fifo_level,
  input wire base_irq_pending,
  input wire tx_pending,
  input wire tx_between_chars,
  input wire flow_char_taken,
  input wire tx_serial,
  input wire tx_bit_start,
  input wire peer_sleep_ok,
  input wire rx_pin,
  input wire cts_n,
  input wire dsr_n,
  input wire cd_n,
  input wire ri_n,
  output reg rx_store_valid_ff,
  output reg [7:0] rx_store_data_ff,
  output reg tx_wr_valid_ff,
  output reg [7:0] tx_wr_data_ff,
  output reg tx_pause_ff,
  output reg flow_char_valid_ff,
  output reg [7:0] flow_char_ff,
  output reg tx_pin_ff,
  output reg rx_serial_ff,
  output reg irq_ff,
  output reg asleep_ff,
  output reg sleep_ok_ff,
  output reg osc_output_pin_ff
);
// ****************************************
// Registers
// ****************************************
reg [7:0] ier_ff, efr_ff, lcr_ff, mcr_ff;
reg [7:0] xon1_ff, xon2_ff, xoff1_ff, special_match_char_ff;
reg [15:0] div_ff;
reg [1:0] trig_ff;
reg xoff_flag_ff, spec_flag_ff;
reg [3:0] msr_q_ff, msr_d_ff;
reg held_v_ff, held_on_ff, pend_v_ff;
reg [7:0] held_d_ff, pend_d_ff;
reg [15:0] div_cnt_ff;
reg [8:0] dly_cnt_ff;
reg dly_run_ff, xoff_sent_ff;
reg snd_second_ff, snd_is_off_ff;
reg [3:0] ir_cnt_ff;
reg rx_pin_q_ff;
wire acc = psel & penable & pready_ff;
wire wr = acc & pwrite;
wire rd = acc & ~pwrite;
wire key = (lcr_ff == `UXS_LCR_KEY);
// ****************************************
// APB register access
// ****************************************
reg [31:0] rdata;
reg hit;
always @* begin
  rdata = 32'h0;
  hit = 1'b1;
  if (paddr == `UXS_A_DATA) begin
    rdata = {24'h0, rx_store_data_ff};
  end else if (paddr == `UXS_A_IER) begin
    rdata = {24'h0, ier_ff};
  end else if (paddr == `UXS_A_ISR) begin
    rdata = {27'h0, xoff_flag_ff | spec_flag_ff, 3'h0, ~irq_ff};
  end else if (paddr == `UXS_A_EFR) begin
    rdata = {24'h0, efr_ff};
  end else if (paddr == `UXS_A_LCR) begin
    rdata = {24'h0, lcr_ff};
  end else if (paddr == `UXS_A_MCR) begin
    rdata = {24'h0, mcr_ff};
  end else if (paddr == `UXS_A_MSR) begin
    rdata = {24'h0, ~msr_q_ff, msr_d_ff};
  // (RQ22) Key gated reads
  end else if (paddr == `UXS_A_XON1) begin
    rdata = key ? {24'h0, xon1_ff} : 32'h0;
  end else if (paddr == `UXS_A_XON2) begin
    rdata = key ? {24'h0, xon2_ff} : 32'h0;
  end else if (paddr == `UXS_A_XOFF1) begin
    rdata = key ? {24'h0, xoff1_ff} : 32'h0;
  end else if (paddr == `UXS_A_SPECIAL_MATCH_CHAR) begin
    rdata = key ? {24'h0, special_match_char_ff} : 32'h0;
  end else if (paddr == `UXS_A_DIV) begin
    rdata = {16'h0, div_ff};
  end else if (paddr == `UXS_A_TRIG) begin
    rdata = {30'h0, trig_ff};
  end else begin
    hit = 1'b0;
  end
end
always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    pready_ff <= 1'b0;
    pslverr_ff <= 1'b0;
    prdata_ff <= 32'h0;
    ier_ff <= 8'h00;
    efr_ff <= 8'h00;
    lcr_ff <= `UXS_LCR_RST;
    mcr_ff <= 8'h00;
    div_ff <= `UXS_DIV_RST;
    trig_ff <= 2'h0;
    // (RQ5) Flow chars cleared
    xon1_ff <= `UXS_XCHAR_RST;
    xon2_ff <= `UXS_XCHAR_RST;
    xoff1_ff <= `UXS_XCHAR_RST;
    special_match_char_ff <= `UXS_XCHAR_RST;
    tx_wr_valid_ff <= 1'b0;
    tx_wr_data_ff <= 8'h00;
  end else begin
    pready_ff <= psel & penable & ~pready_ff;
    pslverr_ff <= psel & penable & ~pready_ff & ~hit;
    if (psel & penable & ~pready_ff & ~pwrite) begin
      prdata_ff <= rdata;
    end
    tx_wr_valid_ff <= wr & (paddr == `UXS_A_DATA);
    if (wr) begin
      if (paddr == `UXS_A_DATA) begin
        tx_wr_data_ff <= pwdata[7:0];
      end else if (paddr == `UXS_A_IER) begin
        ier_ff <= pwdata[7:0];
      end else if (paddr == `UXS_A_EFR) begin
        efr_ff <= pwdata[7:0];
      end else if (paddr == `UXS_A_LCR) begin
        lcr_ff <= pwdata[7:0];
      end else if (paddr == `UXS_A_MCR) begin
        mcr_ff <= pwdata[7:0];
      end else if (paddr == `UXS_A_DIV) begin
        div_ff <= pwdata[15:0];
      end else if (paddr == `UXS_A_TRIG) begin
        trig_ff <= pwdata[1:0];
      // (RQ22) Key gated writes
      end else if (paddr == `UXS_A_XON1 && key) begin
        xon1_ff <= pwdata[7:0];
      end else if (paddr == `UXS_A_XON2 && key) begin
        xon2_ff <= pwdata[7:0];
      end else if (paddr == `UXS_A_XOFF1 && key) begin
        xoff1_ff <= pwdata[7:0];
      end else if (paddr == `UXS_A_SPECIAL_MATCH_CHAR && key) begin
        special_match_char_ff <= pwdata[7:0];
      end
    end
  end
end
// ****************************************
// Receive flow character matching
// ****************************************
// (RQ21) Enables need enhanced bit
wire xoff_ie = ier_ff[`UXS_IER_XOFF] & efr_ff[`UXS_EFR_ENH];
wire sleep_en = ier_ff[`UXS_IER_SLEEP] & efr_ff[`UXS_EFR_ENH];
// (RQ11) Word length mask
wire [7:0] wmask = (lcr_ff[1:0] == 2'd0) ? 8'h1F : (lcr_ff[1:0] == 2'd1) ? 8'h3F :
                   (lcr_ff[1:0] == 2'd2) ? 8'h7F : 8'hFF;
wire m_on1 = ((rx_char ^ xon1_ff) & wmask) == 8'h00;
wire m_on2 = ((rx_char ^ xon2_ff) & wmask) == 8'h00;
wire m_off1 = ((rx_char ^ xoff1_ff) & wmask) == 8'h00;
wire m_off2 = ((rx_char ^ special_match_char_ff) & wmask) == 8'h00;
wire sgl = (efr_ff[1:0] == 2'd1) | (efr_ff[1:0] == 2'd2);
wire dbl = (efr_ff[1:0] == 2'd3);
wire m_on_s = efr_ff[1] ? m_on2 : m_on1;
wire m_off_s = efr_ff[1] ? m_off2 : m_off1;
// (RQ1) Single character compare
wire sgl_on = sgl & rx_char_valid & m_on_s;
wire sgl_off = sgl & rx_char_valid & m_off_s & ~m_on_s;
// (RQ6) Second of a pair
wire pair_hit = dbl & rx_char_valid & held_v_ff & (held_on_ff ? m_on2 : m_off2);
wire first = dbl & rx_char_valid & ~pair_hit & (m_on1 | m_off1);
wire hit_on = sgl_on | (pair_hit & held_on_ff);
wire hit_off = sgl_off | (pair_hit & ~held_on_ff);
wire consumed = sgl_on | sgl_off | pair_hit | first;
always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    rx_store_valid_ff <= 1'b0;
    rx_store_data_ff <= 8'h00;
    held_v_ff <= 1'b0;
    held_on_ff <= 1'b0;
    held_d_ff <= 8'h00;
    pend_v_ff <= 1'b0;
    pend_d_ff <= 8'h00;
    tx_pause_ff <= 1'b0;
  end else begin
    rx_store_valid_ff <= 1'b0;
    pend_v_ff <= 1'b0;
    if (pend_v_ff) begin
      rx_store_valid_ff <= 1'b1;
      rx_store_data_ff <= pend_d_ff;
    end
    if (rx_char_valid) begin
      held_v_ff <= first;
      if (first) begin
        held_d_ff <= rx_char;
        held_on_ff <= m_on1;
      end
      // (RQ7) Flow chars not stored
      if (held_v_ff & ~pair_hit) begin
        rx_store_valid_ff <= 1'b1;
        rx_store_data_ff <= held_d_ff;
        pend_v_ff <= ~consumed;
        pend_d_ff <= rx_char;
      end else if (~consumed) begin
        rx_store_valid_ff <= 1'b1;
        rx_store_data_ff <= rx_char;
      end
    end
    // (RQ2) Pause at char boundary
    if (hit_off) begin
      tx_pause_ff <= 1'b1;
    // (RQ4) Resume on Xon
    end else if (hit_on) begin
      tx_pause_ff <= 1'b0;
    end
  end
end
// ****************************************
// Flags and modem change tracking
// ****************************************
wire [3:0] modem_in = {~ri_n, ~cd_n, ~dsr_n, ~cts_n};
wire isr_rd = rd & (paddr == `UXS_A_ISR);
wire msr_rd = rd & (paddr == `UXS_A_MSR);
wire spec_hit = efr_ff[`UXS_EFR_SPEC] & rx_char_valid & ~consumed & m_off2;
always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    xoff_flag_ff <= 1'b0;
    spec_flag_ff <= 1'b0;
    msr_q_ff <= 4'h0;
  end else begin
    msr_q_ff <= modem_in;
    // (RQ3) Xoff flag when enabled
    if (hit_off & xoff_ie) begin
      xoff_flag_ff <= 1'b1;
    // (RQ4) Xon clears flag
    end else if (hit_on) begin
      xoff_flag_ff <= 1'b0;
    end
    // (RQ10) Special char flag
    if (spec_hit) begin
      spec_flag_ff <= 1'b1;
    end else if (isr_rd) begin
      spec_flag_ff <= 1'b0;
    end
  end
end
genvar gi;
generate
  for (gi = 0; gi < 4; gi = gi + 1) begin : g_msr
    // (RQ19) Read clears, change wins
    always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        msr_d_ff[gi] <= 1'b0;
      end else if (modem_in[gi] != msr_q_ff[gi]) begin
        msr_d_ff[gi] <= 1'b1;
      end else if (msr_rd) begin
        msr_d_ff[gi] <= 1'b0;
      end
    end
  end
endgenerate
// ****************************************
// Bit timing and automatic Xoff/Xon send
// ****************************************
wire tick = (div_cnt_ff >= div_ff - 16'd1);
// (RQ24) Frame length in bits
wire [3:0] frame = 4'd7 + {2'b00, lcr_ff[1:0]} + {3'b000, lcr_ff[`UXS_LCR_PAR]} + {3'b000, lcr_ff[`UXS_LCR_STOP]};
wire [8:0] dly_ticks = {frame, 5'h00};
reg [5:0] trig_lvl, xon_lvl;
always @* begin
  case (trig_ff)
    2'd0: begin trig_lvl = 6'd8; xon_lvl = 6'd0; end
    2'd1: begin trig_lvl = 6'd16; xon_lvl = 6'd8; end
    2'd2: begin trig_lvl = 6'd24; xon_lvl = 6'd16; end
    default: begin trig_lvl = 6'd28; xon_lvl = 6'd24; end
  endcase
end
wire tx_flow_en = (efr_ff[3:2] != 2'd0);
wire send_pair = (efr_ff[3:2] == 2'd3);
wire send_off = dly_run_ff & tick & (dly_cnt_ff + 9'd1 >= dly_ticks);
wire send_on = xoff_sent_ff & ~dly_run_ff & (rx_fifo_level <= xon_lvl);
wire [7:0] c_off1 = (efr_ff[3:2] == 2'd2) ? special_match_char_ff : xoff1_ff;
wire [7:0] c_on1 = (efr_ff[3:2] == 2'd2) ? xon2_ff : xon1_ff;
always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    div_cnt_ff <= 16'h0;
    dly_cnt_ff <= 9'h0;
    dly_run_ff <= 1'b0;
    xoff_sent_ff <= 1'b0;
    flow_char_valid_ff <= 1'b0;
    flow_char_ff <= 8'h00;
    snd_second_ff <= 1'b0;
    snd_is_off_ff <= 1'b0;
  end else begin
    div_cnt_ff <= tick ? 16'h0 : div_cnt_ff + 16'd1;
    // (RQ8) Delay after trigger crossing
    if (~tx_flow_en) begin
      dly_run_ff <= 1'b0;
      xoff_sent_ff <= 1'b0;
    end else if (~xoff_sent_ff & ~dly_run_ff & (rx_fifo_level >= trig_lvl)) begin
      dly_run_ff <= 1'b1;
      dly_cnt_ff <= 9'h0;
    end else if (dly_run_ff & tick) begin
      dly_cnt_ff <= dly_cnt_ff + 9'd1;
    end
    // (RQ23) Offer only between chars
    if (flow_char_valid_ff) begin
      if (flow_char_taken) begin
        snd_second_ff <= 1'b0;
        flow_char_valid_ff <= snd_second_ff;
        flow_char_ff <= snd_is_off_ff ? special_match_char_ff : xon2_ff;
      end
    end else if (send_off & tx_between_chars) begin
      dly_run_ff <= 1'b0;
      xoff_sent_ff <= 1'b1;
      flow_char_valid_ff <= 1'b1;
      flow_char_ff <= c_off1;
      snd_second_ff <= send_pair;
      snd_is_off_ff <= 1'b1;
    // (RQ9) Xon one step below
    end else if (send_on & tx_between_chars) begin
      xoff_sent_ff <= 1'b0;
      flow_char_valid_ff <= 1'b1;
      flow_char_ff <= c_on1;
      snd_second_ff <= send_pair;
      snd_is_off_ff <= 1'b0;
    end
  end
end
// ****************************************
// Infrared encoder and decoder
// ****************************************
wire ir_on = mcr_ff[`UXS_MCR_IR];
always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    ir_cnt_ff <= `UXS_IR_CNT_MAX;
    tx_pin_ff <= 1'b1;
    rx_serial_ff <= 1'b1;
  end else begin
    if (tx_bit_start) begin
      ir_cnt_ff <= 4'h0;
    end else if (tick && ir_cnt_ff != `UXS_IR_CNT_MAX) begin
      ir_cnt_ff <= ir_cnt_ff + 4'd1;
    end
    // (RQ12) 3/16 pulse per zero
    // (RQ13) Idles low in IR mode
    if (ir_on) begin
      tx_pin_ff <= ~tx_serial & ~tx_bit_start & (ir_cnt_ff < `UXS_IR_PULSE_TICKS);
    end else begin
      tx_pin_ff <= tx_serial;
    end
    // (RQ14) Pulse to high, invertible
    rx_serial_ff <= ir_on ? (rx_pin ^ mcr_ff[`UXS_MCR_INV]) : rx_pin;
  end
end
// ****************************************
// Interrupt and sleep control
// ****************************************
wire own_int = (xoff_flag_ff & xoff_ie) | spec_flag_ff;
wire int_pend = own_int | base_irq_pending;
// (RQ17) Wake events
wire wake = (rx_pin_q_ff & ~rx_pin) | (wr & (paddr == `UXS_A_DATA)) | (modem_in != msr_q_ff);
// (RQ15) All idle conditions
wire can_sleep = ~int_pend & sleep_en & (msr_d_ff == 4'h0) & rx_pin & ~tx_pending & ~tx_wr_valid_ff;
always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    irq_ff <= 1'b0;
    asleep_ff <= 1'b0;
    sleep_ok_ff <= 1'b0;
    rx_pin_q_ff <= 1'b1;
    osc_output_pin_ff <= 1'b0;
  end else begin
    rx_pin_q_ff <= rx_pin;
    // (RQ3) Interrupt output
    irq_ff <= own_int;
    sleep_ok_ff <= can_sleep;
    // (RQ18) Resleep once serviced
    // (RQ20) Armed while enabled
    asleep_ff <= can_sleep & peer_sleep_ok & ~wake;
    // (RQ16) Oscillator stops asleep
    if (~asleep_ff) begin
      osc_output_pin_ff <= ~osc_output_pin_ff;
    end
  end
end
endmodule // uxs_top

// ===== dv/uxs_chk_assertions.sv
`timescale 1ns/100ps
module uxs_chk (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire pready_ff,
  input wire rx_char_valid,
  input wire tx_between_chars,
  input wire flow_char_taken,
  input wire base_irq_pending,
  input wire peer_sleep_ok,
  input wire rx_pin,
  input wire cts_n,
  input wire dsr_n,
  input wire cd_n,
  input wire ri_n,
  input wire rx_store_valid_ff,
  input wire tx_wr_valid_ff,
  input wire [7:0] tx_wr_data_ff,
  input wire tx_pause_ff,
  input wire flow_char_valid_ff,
  input wire [7:0] flow_char_ff,
  input wire irq_ff,
  input wire asleep_ff,
  input wire osc_output_pin_ff
);
  // ****
  // Checks
  // ****
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_data_wr;
    psel && penable && pready_ff && pwrite && paddr == 8'h00;
  endsequence
  sequence s_wake;
    asleep_ff && ($fell(rx_pin) || $changed({cts_n, dsr_n, cd_n, ri_n}));
  endsequence
  property p_wr_pulse;
    s_data_wr |=> tx_wr_valid_ff && {24'h000000, tx_wr_data_ff} == ($past(pwdata) & 32'h000000FF);
  endproperty
  a_wr_pulse: assert property (p_wr_pulse) else $error("data write lost");
  property p_wr_wake;
    s_data_wr ##0 asleep_ff |-> ##[1:3] !asleep_ff;
  endproperty
  a_wr_wake: assert property (p_wr_wake) else $error("no wake on write");
  property p_wake;
    s_wake |-> ##[1:3] !asleep_ff;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake on line event");
  property p_enter;
    $rose(asleep_ff) |-> $past(peer_sleep_ok) && !$past(base_irq_pending) && $past(rx_pin);
  endproperty
  a_enter: assert property (p_enter) else $error("sleep with condition unmet");
  property p_no_irq;
    asleep_ff |-> !irq_ff;
  endproperty
  a_no_irq: assert property (p_no_irq) else $error("asleep with irq");
  property p_osc_stop;
    asleep_ff ##1 asleep_ff |-> $stable(osc_output_pin_ff);
  endproperty
  a_osc_stop: assert property (p_osc_stop) else $error("osc runs asleep");
  property p_osc_run;
    !asleep_ff ##1 !asleep_ff[*2] |-> $changed(osc_output_pin_ff);
  endproperty
  a_osc_run: assert property (p_osc_run) else $error("osc stuck awake");
  property p_flow_gap;
    $rose(flow_char_valid_ff) |-> $past(tx_between_chars);
  endproperty
  a_flow_gap: assert property (p_flow_gap) else $error("flow char mid frame");
  property p_flow_hold;
    flow_char_valid_ff && !flow_char_taken |=> flow_char_valid_ff && $stable(flow_char_ff);
  endproperty
  a_flow_hold: assert property (p_flow_hold) else $error("flow char dropped");
  property p_store;
    rx_store_valid_ff |-> $past(rx_char_valid) || $past(rx_char_valid, 2);
  endproperty
  a_store: assert property (p_store) else $error("store without char");
  property p_pause;
    $changed(tx_pause_ff) |-> $past(rx_char_valid);
  endproperty
  a_pause: assert property (p_pause) else $error("pause moved alone");
endmodule // uxs_chk
bind uxs_top uxs_chk uxs_chk_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready_ff,
  .rx_char_valid, .tx_between_chars, .flow_char_taken, .base_irq_pending, .peer_sleep_ok, .rx_pin, .cts_n,
  .dsr_n, .cd_n, .ri_n, .rx_store_valid_ff, .tx_wr_valid_ff, .tx_wr_data_ff, .tx_pause_ff,
  .flow_char_valid_ff, .flow_char_ff, .irq_ff, .asleep_ff, .osc_output_pin_ff);

// ===== dv/uxs_peer.sv
`timescale 1ns/100ps
module uxs_peer #(
  parameter int TAKE_DLY = 3
) (
  input wire pclk,
  input wire presetn,
  input wire flow_char_valid_ff,
  input wire tx_wr_valid_ff,
  output logic flow_char_taken,
  output wire tx_between_chars,
  output logic tx_pending,
  output logic tx_serial,
  output logic tx_bit_start
);
  logic [3:0] tick;
  logic [5:0] busy;
  // ****
  // Transmitter stand-in
  // ****
  // Idle between characters only while no flow char is being taken (busy is zero)
  assign tx_between_chars = (busy == 6'h00);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick <= 4'h0;
      busy <= 6'h00;
      flow_char_taken <= 1'b0;
      tx_pending <= 1'b0;
      tx_serial <= 1'b1;
      tx_bit_start <= 1'b0;
    end else begin
      tick <= tick + 4'h1;
      tx_bit_start <= (tick == 4'hF);
      if (tick == 4'hF) begin
        tx_serial <= !tx_serial;
      end
      tx_pending <= tx_wr_valid_ff || (tx_pending && tick != 4'hF);
      flow_char_taken <= (busy == 6'h01);
      if (busy != 6'h00) begin
        busy <= busy - 6'h01;
      end else if (flow_char_valid_ff && !flow_char_taken) begin
        busy <= 6'(TAKE_DLY);
      end
    end
  end
endmodule // uxs_peer

// ===== dv/test_uart_swflow_ir_sleep.sv
`timescale 1ns/100ps
`include "uxs_defines.vh"
module test_uart_swflow_ir_sleep;
  logic pclk, presetn, psel, penable, pwrite, rx_char_valid, base_irq_pending, peer_sleep_ok;
  logic rx_pin, cts_n, dsr_n, cd_n, ri_n, e;
  logic [7:0] paddr, rx_char, st_d, fl_d;
  logic [31:0] pwdata, q;
  logic [5:0] rx_fifo_level;
  wire [31:0] prdata_ff;
  wire [7:0] rx_store_data_ff, tx_wr_data_ff, flow_char_ff;
  wire pready_ff, pslverr_ff, tx_pending, tx_between_chars, flow_char_taken, tx_serial, tx_bit_start;
  wire rx_store_valid_ff, tx_wr_valid_ff, tx_pause_ff, flow_char_valid_ff, tx_pin_ff, rx_serial_ff;
  wire irq_ff, asleep_ff, sleep_ok_ff, osc_output_pin_ff;
  int fail_count, cmp_count, st_n, n, i;
  byte trg [4] = '{8, 16, 24, 28};
  byte xlv [4] = '{0, 8, 16, 24};
  logic [7:0] xc [4] = '{8'h11, 8'h91, 8'h13, 8'h93};
  uxs_top uxs_top_inst (.*);
  uxs_peer #(.TAKE_DLY(24)) uxs_peer_inst (.*);
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (rx_store_valid_ff === 1'b1) begin
      st_n++;
      st_d = rx_store_data_ff;
    end
    if (flow_char_taken === 1'b1) begin
      fl_d = flow_char_ff;
    end
  end
  // ****
  // Tasks
  // ****
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic end_sim;
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready_ff !== 1'b1 && k < 50);
    q = prdata_ff;
    e = pslverr_ff;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (k >= 50) begin
      chk("pready", 0, 1);
      end_sim();
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input string nm);
    bus(1'b0, a, 32'h00000000);
    chk(nm, q, x);
  endtask
  task automatic rxc(input logic [7:0] c);
    rx_char <= c;
    rx_char_valid <= 1'b1;
    @(posedge pclk);
    rx_char_valid <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask
  task automatic wsl(input logic x);
    for (n = 0; asleep_ff !== x && n < 500; n++) @(posedge pclk);
    chk("asleep", asleep_ff, x);
    if (n >= 500) end_sim();
  endtask
  task automatic wfl(input logic [7:0] c, input int lo, input int hi);
    for (n = 0; flow_char_valid_ff !== 1'b1 && n < 900; n++) @(posedge pclk);
    chk("flow char", flow_char_ff, c);
    chk("flow delay", n >= lo && n <= hi, 1);
    for (i = 0; flow_char_valid_ff !== 1'b0 && i < 99; i++) @(posedge pclk);
    chk("flow end", i < 99, 1);
    if (n >= 900 || i >= 99) end_sim();
  endtask
  // ****
  // Sequence
  // ****
  initial begin
    {presetn, psel, penable, pwrite, rx_char_valid, base_irq_pending} = 6'h00;
    {peer_sleep_ok, rx_pin, cts_n, dsr_n, cd_n, ri_n} = 6'h3F;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    rx_char = 8'h00;
    rx_fifo_level = 6'h00;
    {fail_count, cmp_count, st_n} = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(`UXS_A_LCR, 32'h00000003, "lcr rst");
    rd(`UXS_A_DIV, 32'h00000001, "div rst");
    bus(1'b0, 8'h3C, 32'h00000000);
    chk("unmapped", e, 1);
    bus(1'b1, `UXS_A_XON1, 32'h00000055);
    bus(1'b1, `UXS_A_LCR, `UXS_LCR_KEY);
    rd(`UXS_A_XON1, 32'h00000000, "xon1 rst");
    for (int j = 0; j < 4; j++) bus(1'b1, 8'h1C + 8'(4 * j), xc[j]);
    for (int j = 0; j < 4; j++) rd(8'h1C + 8'(4 * j), xc[j], "xchar");
    bus(1'b1, `UXS_A_LCR, 32'h00000003);
    rd(`UXS_A_XOFF1, 32'h00000000, "xchar locked");
    bus(1'b1, `UXS_A_EFR, 32'h00000011);
    bus(1'b1, `UXS_A_IER, 32'h00000020);
    rxc(8'h13);
    chk("pause", tx_pause_ff, 1);
    chk("irq", irq_ff, 1);
    chk("no store", st_n, 0);
    rxc(8'h41);
    rd(`UXS_A_DATA, 32'h00000041, "rx data");
    rxc(8'h11);
    chk("resume", tx_pause_ff, 0);
    rd(`UXS_A_ISR, 32'h00000001, "isr");
    bus(1'b1, `UXS_A_LCR, 32'h00000000);
    rxc(8'hF3);
    chk("pause 5b", tx_pause_ff, 1);
    rxc(8'hF1);
    chk("resume 5b", tx_pause_ff, 0);
    bus(1'b1, `UXS_A_LCR, 32'h00000003);
    bus(1'b1, `UXS_A_EFR, 32'h00000013);
    st_n = 0;
    rxc(8'h13);
    rxc(8'h93);
    chk("pause pair", tx_pause_ff, 1);
    rxc(8'h11);
    rxc(8'h42);
    chk("held store", {st_n[7:0], st_d}, 16'h0242);
    rxc(8'h11);
    rxc(8'h91);
    chk("resume pair", tx_pause_ff, 0);
    bus(1'b1, `UXS_A_EFR, 32'h00000030);
    st_n = 0;
    rxc(8'h93);
    chk("special", {st_n[7:0], st_d}, 16'h0193);
    bus(1'b0, `UXS_A_ISR, 32'h00000000);
    chk("spec flag", q[4], 1);
    bus(1'b1, `UXS_A_EFR, 32'h00000014);
    for (int k = 0; k < 4; k++) begin
      bus(1'b1, `UXS_A_TRIG, 32'(k));
      rx_fifo_level <= 6'(trg[k]);
      wfl(8'h13, 320, 330);
      rx_fifo_level <= 6'(xlv[k] + 1);
      repeat (30) @(posedge pclk);
      chk("early xon", flow_char_valid_ff, 0);
      rx_fifo_level <= 6'(xlv[k]);
      wfl(8'h11, 0, 10);
    end
    rx_fifo_level <= 6'h00;
    bus(1'b1, `UXS_A_EFR, 32'h0000001C);
    bus(1'b1, `UXS_A_TRIG, 32'h00000000);
    rx_fifo_level <= 6'h08;
    wfl(8'h13, 320, 330);
    chk("xoff pair", fl_d, 8'h93);
    rx_fifo_level <= 6'h00;
    wfl(8'h11, 0, 10);
    chk("xon pair", fl_d, 8'h91);
    bus(1'b1, `UXS_A_MCR, 32'h00000040);
    for (n = 0; !(tx_bit_start === 1'b1 && tx_serial === 1'b1) && n < 99; n++) @(posedge pclk);
    chk("bit start", n < 99, 1);
    n = 0;
    repeat (64) begin
      @(posedge pclk);
      n = n + 32'(tx_pin_ff === 1'b1);
    end
    chk("ir pulses", n, 6);
    rx_pin <= 1'b0;
    repeat (3) @(posedge pclk);
    chk("ir rx", rx_serial_ff, 0);
    bus(1'b1, `UXS_A_MCR, 32'h00000044);
    @(posedge pclk);
    chk("ir inv", rx_serial_ff, 1);
    rx_pin <= 1'b1;
    bus(1'b1, `UXS_A_MCR, 32'h00000000);
    bus(1'b1, `UXS_A_EFR, 32'h00000010);
    bus(1'b1, `UXS_A_IER, 32'h00000010);
    wsl(1'b1);
    peer_sleep_ok <= 1'b0;
    wsl(1'b0);
    chk("own ok", sleep_ok_ff, 1);
    peer_sleep_ok <= 1'b1;
    wsl(1'b1);
    cts_n <= 1'b0;
    wsl(1'b0);
    repeat (40) @(posedge pclk);
    chk("delta awake", asleep_ff, 0);
    bus(1'b0, `UXS_A_MSR, 32'h00000000);
    chk("msr delta", q[3:0], 4'h1);
    wsl(1'b1);
    rx_pin <= 1'b0;
    wsl(1'b0);
    rx_pin <= 1'b1;
    wsl(1'b1);
    bus(1'b1, `UXS_A_DATA, 32'h00000055);
    chk("wr wake", asleep_ff, 0);
    wsl(1'b1);
    bus(1'b1, `UXS_A_IER, 32'h00000000);
    wsl(1'b0);
    base_irq_pending <= 1'b1;
    bus(1'b1, `UXS_A_IER, 32'h00000010);
    repeat (60) @(posedge pclk);
    chk("irq awake", asleep_ff, 0);
    chk("irq not ok", sleep_ok_ff, 0);
    base_irq_pending <= 1'b0;
    bus(1'b1, `UXS_A_EFR, 32'h00000000);
    repeat (60) @(posedge pclk);
    chk("enh off", asleep_ff, 0);
    end_sim();
  end
endmodule // test_uart_swflow_ir_sleep
